// file: logic/psc_config_top.sv
// Configuration logic of the PLL synthesizer: pin loading, latches, reference select, output path, APB slave.
//
// The placing of the registers and register access over APB were left to the implementer.
`include "psc_defs.svh"
`timescale 1ns/10ps

// Behaviour
// [RULE1] Output divider: 00/2, 01/4, 10/8, 11/1.
// [RULE2] Select high picks crystal, low external reference.
// [RULE3] Outputs active while gate high, disabled low.
// [RULE4] Gate changes applied synchronously, never runt pulses.
// [RULE5] Serial clock rise shifts serial data in.
// [RULE6] Serial strobe high: transparent; falling edge holds.
// [RULE7] Host keeps shift contents stable around strobe fall.
// [RULE8] Parallel strobe low: transparent; rising edge holds.
// [RULE9] Host holds parallel inputs across strobe rise.
// [RULE10] Loop divider is nine bits, bit8 MSB.
// [RULE11] Output divider select captured on parallel strobe.
// [RULE12] Test output chosen by serial-only test field.
// [RULE13] VCO clock feeds divider, divider drives output.
// [RULE14] Unconnected inputs read their fixed default levels.
// [RULE15] Both paths share latches; last closed wins.
module psc_config_top #(
    parameter int PADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_load,
    input wire logic serial_data,
    input wire logic serial_clock,
    input wire logic parallel_load,
    input wire logic [8:0] loop_div_in,
    input wire logic [1:0] out_div_in,
    input wire logic output_gate,
    input wire logic reference_source_select,
    input wire logic external_reference_in,
    input wire logic xtal_clk_in,
    input wire logic vco_clk_in,
    output logic pll_ref_clk,
    output logic [8:0] loop_div,
    output logic [1:0] out_div_sel,
    output logic f_out,
    output logic f_out_n,
    output logic test_out
);
    if (PADDR_W < 4) begin : g_bad_addr
        $error("psc_config_top needs at least four address bits");
    end

    psc_pkg::psc_core_state_t st;
    psc_pkg::psc_core_state_t next_st;

    logic [19:0] pins;
    logic [19:0] lvl;
    logic p_sload;
    logic p_sdata;
    logic p_sclk;
    logic p_pload;
    logic [8:0] p_m;
    logic [1:0] p_n;
    logic p_gate;
    logic p_refsel;
    logic p_extref;
    logic p_xtal;
    logic p_vco;
    logic eff_sload;
    logic eff_sdata;
    logic eff_sclk;
    logic eff_pload;
    logic [8:0] eff_m;
    logic [1:0] eff_n;
    logic eff_gate;
    logic eff_refsel;
    logic eff_extref;
    logic sclk_rise;
    logic raw_clk;
    logic setup;
    logic wr_access;
    logic [11:0] addr;
    logic [31:0] status_word;

    ////////////////////////////////////////////////////////////////////////////////
    // Every pin crosses into pclk through one filtered synchroniser; the VCO and crystal are only
    // observed as sampled levels, so this model is exact only when pclk outruns them.
    assign pins = {vco_clk_in, xtal_clk_in, external_reference_in, reference_source_select, output_gate,
                   out_div_in, loop_div_in, parallel_load, serial_clock, serial_data, serial_load};

    psc_pin_sync #(
        .W(20),
        .RST_VAL(`PSC_PIN_RST)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(pins),
        .level(lvl)
    );

    assign p_sload = lvl[0];
    assign p_sdata = lvl[1];
    assign p_sclk = lvl[2];
    assign p_pload = lvl[3];
    assign p_m = lvl[12:4];
    assign p_n = lvl[14:13];
    assign p_gate = lvl[15];
    assign p_refsel = lvl[16];
    assign p_extref = lvl[17];
    assign p_xtal = lvl[18];
    assign p_vco = lvl[19];

    // A pin marked unconnected in the float register reads as its pull level instead of the pad.
    always_comb begin
        eff_sload = st.pin_float[`PSC_FLT_SLOAD] ? `PSC_PIN_DFLT_LO : p_sload; // RULE14
        eff_sdata = st.pin_float[`PSC_FLT_SDATA] ? `PSC_PIN_DFLT_LO : p_sdata; // RULE14
        eff_sclk = st.pin_float[`PSC_FLT_SCLK] ? `PSC_PIN_DFLT_LO : p_sclk; // RULE14
        eff_extref = st.pin_float[`PSC_FLT_EXTREF] ? `PSC_PIN_DFLT_LO : p_extref; // RULE14
        eff_pload = st.pin_float[`PSC_FLT_PLOAD] ? `PSC_PIN_DFLT_HI : p_pload; // RULE14
        eff_m = st.pin_float[`PSC_FLT_M] ? {9{`PSC_PIN_DFLT_HI}} : p_m; // RULE14
        eff_n = st.pin_float[`PSC_FLT_N] ? {2{`PSC_PIN_DFLT_HI}} : p_n; // RULE14
        eff_gate = st.pin_float[`PSC_FLT_GATE] ? `PSC_PIN_DFLT_HI : p_gate; // RULE14
        eff_refsel = st.pin_float[`PSC_FLT_REFSEL] ? `PSC_PIN_DFLT_HI : p_refsel; // RULE14
    end

    assign sclk_rise = eff_sclk & ~st.sclk_q;
    assign addr = 12'(paddr);
    assign setup = psel & ~penable;
    assign wr_access = psel & penable & pwrite;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`PSC_ST_M_LSB +: 9] = st.loop_div;
        status_word[`PSC_ST_N_LSB +: 2] = st.odiv;
        status_word[`PSC_ST_T_LSB +: 3] = st.test;
        status_word[`PSC_ST_GATE_BIT] = eff_gate;
        status_word[`PSC_ST_REF_BIT] = eff_refsel;
        status_word[`PSC_ST_SRC_BIT] = st.src;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.sclk_q = eff_sclk;

        if (sclk_rise) begin
            next_st.shift = {st.shift[12:0], eff_sdata}; // RULE5
        end

        // The latches are modelled as clocked followers: open means they copy their source every cycle,
        // closed means they keep what they last copied. The serial path wins while both stand open.
        if (eff_sload) begin
            next_st.loop_div = next_st.shift[`PSC_SH_M_LSB +: 9]; // RULE6
            next_st.odiv = psc_pkg::psc_odiv_t'(next_st.shift[`PSC_SH_N_LSB +: 2]); // RULE6
            next_st.test = next_st.shift[`PSC_SH_T_LSB +: 3]; // RULE12
            next_st.src = psc_pkg::psc_src_ser; // RULE15
        end else if (!eff_pload) begin
            next_st.loop_div = eff_m; // RULE10
            next_st.odiv = psc_pkg::psc_odiv_t'(eff_n); // RULE11
            next_st.src = psc_pkg::psc_src_par; // RULE8
        end

        next_st.ref_clk = eff_refsel ? p_xtal : eff_extref; // RULE2

        case (psc_pkg::psc_test_t'(st.test))
            psc_pkg::psc_tst_low: next_st.test_out = 1'b0;
            psc_pkg::psc_tst_ref: next_st.test_out = next_st.ref_clk; // RULE12
            psc_pkg::psc_tst_vco: next_st.test_out = p_vco;
            psc_pkg::psc_tst_fout: next_st.test_out = raw_clk;
            psc_pkg::psc_tst_sdata: next_st.test_out = eff_sdata;
            psc_pkg::psc_tst_high: next_st.test_out = 1'b1;
            default: next_st.test_out = 1'b0;
        endcase

        // Read data and the error flag are prepared in the setup phase so the slave can answer with no wait.
        if (setup) begin
            next_st.pslverr = 1'b0;
            case (addr)
                `PSC_ADDR_PIN_FLOAT: next_st.prdata = {23'h000000, st.pin_float};
                `PSC_ADDR_STATUS: begin
                    next_st.prdata = status_word;
                    next_st.pslverr = pwrite;
                end
                `PSC_ADDR_SHIFT: begin
                    next_st.prdata = {18'h00000, st.shift};
                    next_st.pslverr = pwrite;
                end
                default: begin
                    next_st.prdata = 32'h0000_0000;
                    next_st.pslverr = 1'b1;
                end
            endcase
        end

        if (wr_access && addr == `PSC_ADDR_PIN_FLOAT) begin
            if (pstrb[0]) begin
                next_st.pin_float[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                next_st.pin_float[8] = pwdata[8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{shift: `PSC_SHIFT_RST, loop_div: `PSC_M_RST, odiv: psc_pkg::psc_div1, test: `PSC_T_RST,
                   src: psc_pkg::psc_src_par, sclk_q: 1'b0, pin_float: `PSC_PIN_FLOAT_RST,
                   prdata: 32'h0000_0000, pslverr: 1'b0, ref_clk: 1'b0, test_out: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    psc_out_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .vco_level(p_vco),
        .odiv(st.odiv),
        .gate_req(eff_gate),
        .raw_clk(raw_clk),
        .f_out(f_out),
        .f_out_n(f_out_n)
    );

    assign prdata = st.prdata;
    assign pready = 1'b1;
    assign pslverr = st.pslverr & psel & penable;
    assign pll_ref_clk = st.ref_clk;
    assign loop_div = st.loop_div;
    assign out_div_sel = st.odiv;
    assign test_out = st.test_out;

    ////////////////////////////////////////////////////////////////////////////////
    shift_in_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        sclk_rise |=> (st.shift == {$past(st.shift[12:0]), $past(eff_sdata)}))
        else $error("serial bit not shifted on clock rise");
    shift_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        !sclk_rise |=> $stable(st.shift)) else $error("shift register moved without clock rise");
    serial_pass_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        eff_sload |=> ({st.test, st.odiv, st.loop_div} == st.shift)) else $error("serial latch not transparent");
    par_pass_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        (!eff_pload && !eff_sload) |=> ({st.odiv, st.loop_div} == $past({eff_n, eff_m})))
        else $error("parallel latch not transparent");
    hold_cfg_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
        (eff_pload && !eff_sload)[*2] |=> $stable({st.test, st.odiv, st.loop_div}))
        else $error("closed latches changed");
    test_serial_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        !eff_sload |=> (st.test == $past(st.test))) else $error("test field loaded off the serial path");
    ref_sel_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        eff_refsel |=> (pll_ref_clk == $past(p_xtal))) else $error("crystal not selected as reference");
    ref_ext_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        !eff_refsel |=> (pll_ref_clk == $past(eff_extref))) else $error("external reference not selected");
    float_dflt_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
        st.pin_float[`PSC_FLT_PLOAD] |-> (eff_pload && !(st.pin_float[`PSC_FLT_SLOAD] && eff_sload)))
        else $error("floating strobe not at default level");
    src_track_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
        eff_sload |=> (st.src == psc_pkg::psc_src_ser)) else $error("load source not tracked");
    serial_load_c: cover property (@(posedge pclk) disable iff (!presetn) $fell(eff_sload));
    par_load_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(eff_pload) && !eff_sload);
    float_c: cover property (@(posedge pclk) disable iff (!presetn) st.pin_float != 9'h000);
endmodule : psc_config_top

// file: logic/psc_defs.svh
// Register map, field positions, reset values and counts of the synthesizer configuration logic.
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH

`define PSC_ADDR_PIN_FLOAT 12'h000
`define PSC_ADDR_STATUS 12'h004
`define PSC_ADDR_SHIFT 12'h008

`define PSC_ST_M_LSB 0
`define PSC_ST_N_LSB 9
`define PSC_ST_T_LSB 11
`define PSC_ST_GATE_BIT 14
`define PSC_ST_REF_BIT 15
`define PSC_ST_SRC_BIT 16

`define PSC_FLT_SLOAD 0
`define PSC_FLT_SDATA 1
`define PSC_FLT_SCLK 2
`define PSC_FLT_EXTREF 3
`define PSC_FLT_PLOAD 4
`define PSC_FLT_M 5
`define PSC_FLT_N 6
`define PSC_FLT_GATE 7
`define PSC_FLT_REFSEL 8

`define PSC_SH_M_LSB 0
`define PSC_SH_N_LSB 9
`define PSC_SH_T_LSB 11

`define PSC_PIN_FLOAT_RST 9'h000
`define PSC_M_RST 9'h1ff
`define PSC_N_RST 2'h3
`define PSC_T_RST 3'h0
`define PSC_SHIFT_RST 14'h0000
`define PSC_PIN_RST 20'h1fff8
`define PSC_PIN_DFLT_LO 1'b0
`define PSC_PIN_DFLT_HI 1'b1

`define PSC_HALF_M1_DIV2 2'h0
`define PSC_HALF_M1_DIV4 2'h1
`define PSC_HALF_M1_DIV8 2'h3

`endif

// file: logic/psc_pkg.sv
// Types shared by the synthesizer configuration logic.
package psc_pkg;
    typedef enum logic [1:0] {psc_div2 = 2'h0, psc_div4 = 2'h1, psc_div8 = 2'h2, psc_div1 = 2'h3} psc_odiv_t;
    typedef enum logic [1:0] {psc_gate_off = 2'h1, psc_gate_on = 2'h2} psc_gate_t;
    typedef enum logic {psc_src_par = 1'h0, psc_src_ser = 1'h1} psc_src_t;
    typedef enum logic [2:0] {
        psc_tst_low = 3'h0,
        psc_tst_ref = 3'h1,
        psc_tst_vco = 3'h2,
        psc_tst_fout = 3'h3,
        psc_tst_sdata = 3'h4,
        psc_tst_high = 3'h7
    } psc_test_t;

    typedef struct packed {
        logic [13:0] shift;
        logic [8:0] loop_div;
        psc_odiv_t odiv;
        logic [2:0] test;
        psc_src_t src;
        logic sclk_q;
        logic [8:0] pin_float;
        logic [31:0] prdata;
        logic pslverr;
        logic ref_clk;
        logic test_out;
    } psc_core_state_t;

    typedef struct packed {
        logic [1:0] cnt;
        logic raw;
        logic vco_q;
        psc_gate_t gate;
        logic out;
        logic out_n;
    } psc_div_state_t;
endpackage : psc_pkg

// file: logic/psc_pin_sync.sv
// Three-stage input synchroniser with agreement filter for the device pins.
`timescale 1ns/10ps
module psc_pin_sync #(
    parameter int W = 20,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } psc_sync_state_t;

    psc_sync_state_t st;
    psc_sync_state_t next_st;

    if (W < 1) begin : g_bad_width
        $error("psc_pin_sync needs at least one bit");
    end

    // A bit only moves once the second and third stages agree, so a sample caught mid-transition never leaks out.
    always_comb begin
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.lvl = (st.s2 & ~(st.s2 ^ st.s3)) | (st.lvl & (st.s2 ^ st.s3));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign level = st.lvl;
endmodule : psc_pin_sync

// file: logic/psc_out_divider.sv
// Output divider with glitch-free output gate.
`include "psc_defs.svh"
`timescale 1ns/10ps
module psc_out_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic vco_level,
    input psc_pkg::psc_odiv_t odiv,
    input wire logic gate_req,
    output logic raw_clk,
    output logic f_out,
    output logic f_out_n
);
    psc_pkg::psc_div_state_t st;
    psc_pkg::psc_div_state_t next_st;
    logic vco_rise;

    function automatic logic [1:0] half_m1(input psc_pkg::psc_odiv_t sel);
        case (sel)
            psc_pkg::psc_div2: half_m1 = `PSC_HALF_M1_DIV2;
            psc_pkg::psc_div4: half_m1 = `PSC_HALF_M1_DIV4;
            psc_pkg::psc_div8: half_m1 = `PSC_HALF_M1_DIV8;
            default: half_m1 = `PSC_HALF_M1_DIV2;
        endcase
    endfunction : half_m1

    always_comb begin
        next_st = st;
        vco_rise = vco_level & ~st.vco_q;
        next_st.vco_q = vco_level;
        if (odiv == psc_pkg::psc_div1) begin
            next_st.raw = vco_level; // RULE1
            next_st.cnt = 2'h0;
        end else if (vco_rise) begin
            // The >= compare lets a shorter ratio take over cleanly from a longer one mid-count.
            if (st.cnt >= half_m1(odiv)) begin
                next_st.raw = ~st.raw; // RULE13
                next_st.cnt = 2'h0;
            end else begin
                next_st.cnt = st.cnt + 2'h1; // RULE1
            end
        end
        // The gate may only change while the divided clock is low, so no pulse is ever cut short.
        if (!next_st.raw) begin
            next_st.gate = gate_req ? psc_pkg::psc_gate_on : psc_pkg::psc_gate_off; // RULE4
        end
        next_st.out = next_st.raw & (next_st.gate == psc_pkg::psc_gate_on); // RULE3
        next_st.out_n = ~next_st.out;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{cnt: 2'h0, raw: 1'b0, vco_q: 1'b0, gate: psc_pkg::psc_gate_off, out: 1'b0, out_n: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign raw_clk = st.raw;
    assign f_out = st.out;
    assign f_out_n = st.out_n;

    ////////////////////////////////////////////////////////////////////////////////
    gate_sync_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        $changed(st.gate) |-> !st.raw) else $error("output gate changed while divided clock high");
    gate_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        (st.gate == psc_pkg::psc_gate_off) |-> (!f_out && f_out_n)) else $error("output active while gated off");
    gate_on_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
        (st.gate == psc_pkg::psc_gate_on) |-> (f_out == st.raw)) else $error("enabled output not following divider");
    div2_ratio_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        (odiv == psc_pkg::psc_div2 && vco_rise) |=> $changed(st.raw)) else $error("divide-by-2 missed a toggle");
    div1_pass_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        (odiv == psc_pkg::psc_div1) |=> (st.raw == $past(vco_level))) else $error("divide-by-1 not following vco");
    gate_on_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(st.gate == psc_pkg::psc_gate_on));
    div8_c: cover property (@(posedge pclk) disable iff (!presetn) (odiv == psc_pkg::psc_div8) && $rose(st.out));
endmodule : psc_out_divider

// file: bench/psc_host_model.sv
// Host model that drives the serial and parallel configuration pins.
`timescale 1ns/10ps
module psc_host_model (
    input wire logic pclk,
    output logic serial_load,
    output logic serial_data,
    output logic serial_clock,
    output logic parallel_load,
    output logic [8:0] loop_div_in,
    output logic [1:0] out_div_in
);
    initial begin
        serial_load = 1'b0;
        serial_data = 1'b0;
        serial_clock = 1'b0;
        parallel_load = 1'b1;
        loop_div_in = 9'h1ff;
        out_div_in = 2'h3;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The top bit goes first so that it ends at bit 13; the clock idles low between frames.
    task automatic ser_shift(input logic [13:0] w);
        for (int i = 13; i >= 0; i--) begin
            serial_data <= w[i];
            repeat (6) @(posedge pclk);
            serial_clock <= 1'b1;
            repeat (6) @(posedge pclk);
            serial_clock <= 1'b0;
        end
        repeat (6) @(posedge pclk);
        // The data line has a pull-down, so a released line sits low.
        serial_data <= 1'b0;
        @(posedge pclk);
    endtask : ser_shift

    // No clock edge happens while the strobe moves, and the wait keeps the shift contents settled.
    task automatic ser_strobe(input logic v);
        serial_load <= v;
        repeat (10) @(posedge pclk);
    endtask : ser_strobe

    task automatic par_set(input logic [8:0] m, input logic [1:0] n);
        loop_div_in <= m;
        out_div_in <= n;
        repeat (8) @(posedge pclk);
    endtask : par_set

    task automatic par_strobe(input logic v);
        parallel_load <= v;
        repeat (8) @(posedge pclk);
    endtask : par_strobe
endmodule : psc_host_model

// file: bench/pll_synth_config_logic_test.sv
// Self-checking testbench of the synthesizer configuration logic.
`include "psc_defs.svh"
`timescale 1ns/10ps
module pll_synth_config_logic_test;
    typedef struct {logic [31:0] data; logic [31:0] mask; logic err;} psc_note_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fo_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic serial_load, serial_data, serial_clock, parallel_load;
    logic [8:0] loop_div_in, loop_div;
    logic [1:0] out_div_in, out_div_sel, vco_cnt;
    logic output_gate, reference_source_select, external_reference_in, xtal_clk_in, vco_clk_in;
    logic pll_ref_clk, f_out, f_out_n, test_out;
    logic [15:0] rnd;
    logic [13:0] wa, wb;
    int err_total, n_tests, rises, hi_run, min_hi, r0, d;
    psc_note_t notes[$];

    psc_config_top dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .serial_load, .serial_data, .serial_clock, .parallel_load, .loop_div_in, .out_div_in,
        .output_gate, .reference_source_select, .external_reference_in, .xtal_clk_in, .vco_clk_in, .pll_ref_clk,
        .loop_div, .out_div_sel, .f_out, .f_out_n, .test_out);
    psc_host_model host_u (.pclk, .serial_load, .serial_data, .serial_clock, .parallel_load, .loop_div_in,
        .out_div_in);

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // The VCO stand-in has a period of four bus clocks, so the divider can see every edge.
    always @(posedge pclk) vco_cnt <= vco_cnt + 2'h1;
    assign vco_clk_in = vco_cnt[1];

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test

    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_n

    // The expected answer is noted before the request goes out; the watcher below compares it.
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] dat, input logic [31:0] exp,
        input logic [31:0] m, input logic e);
        int n;
        notes.push_back('{exp, m, e});
        paddr <= a;
        pwrite <= w;
        pwdata <= dat;
        pstrb <= {4{w}};
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) check(32'h0, 32'h1, "no ready");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic cfg(input logic [8:0] m, input logic [1:0] n, input string msg);
        check({23'h0, loop_div}, {23'h0, m}, msg);
        check({30'h0, out_div_sel}, {30'h0, n}, msg);
    endtask : cfg

    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge pclk) begin
        if (psel && penable && pready) begin
            if (notes.size() == 0) check(32'h1, 32'h0, "unexpected transfer");
            else begin
                check(prdata & notes[0].mask, notes[0].data & notes[0].mask, "read data");
                check({31'h0, pslverr}, {31'h0, notes[0].err}, "error response");
                void'(notes.pop_front());
            end
        end
        check({31'h0, f_out_n}, {31'h0, ~f_out}, "complement output");
        if (f_out && !fo_q) rises++;
        if (!f_out && fo_q && hi_run < min_hi) min_hi = hi_run;
        hi_run = f_out ? hi_run + 1 : 0;
        fo_q = f_out;
    end

    initial begin
        wait_n(20000);
        check(32'h0, 32'h1, "timeout");
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, fo_q} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        {output_gate, reference_source_select, external_reference_in, xtal_clk_in} = 4'hc;
        vco_cnt = 2'h0;
        rnd = 16'h190a;
        min_hi = 1000;
        wait_n(8);
        cfg(9'h1ff, 2'h3, "reset config");
        presetn <= 1'b1;
        wait_n(10);
        apb(`PSC_ADDR_PIN_FLOAT, 1'b0, 32'h0, 32'h0, 32'h1ff, 1'b0);
        apb(`PSC_ADDR_STATUS, 1'b0, 32'h0, 32'h7ff, 32'h3fff, 1'b0);
        $display("test reset done");
        // Serial path: open strobe, shift again while open, close, then a third frame must not leak.
        rnd = lfsr(rnd);
        wa = {3'h7, rnd[10:0]};
        wb = {3'h0, ~rnd[10:0]};
        host_u.ser_shift(wa);
        host_u.ser_strobe(1'b1);
        cfg(wa[8:0], wa[10:9], "serial open");
        check({31'h0, test_out}, 32'h1, "test high");
        host_u.ser_shift(wb);
        cfg(wb[8:0], wb[10:9], "serial transparent");
        check({31'h0, test_out}, 32'h0, "test low");
        host_u.ser_strobe(1'b0);
        host_u.ser_shift(wa);
        cfg(wb[8:0], wb[10:9], "serial hold");
        apb(`PSC_ADDR_SHIFT, 1'b0, 32'h0, {18'h0, wa}, 32'h3fff, 1'b0);
        apb(`PSC_ADDR_STATUS, 1'b0, 32'h0, {15'h0, 3'h4, wb}, 32'h13fff, 1'b0);
        $display("test serial done");
        // Parallel path overrides the serial load: low follows, rise holds.
        rnd = lfsr(rnd);
        host_u.par_set(rnd[8:0], rnd[10:9]);
        host_u.par_strobe(1'b0);
        cfg(rnd[8:0], rnd[10:9], "parallel open");
        host_u.par_set(~rnd[8:0], ~rnd[10:9]);
        cfg(~rnd[8:0], ~rnd[10:9], "parallel transparent");
        host_u.par_strobe(1'b1);
        host_u.par_set(rnd[8:0], rnd[10:9]);
        cfg(~rnd[8:0], ~rnd[10:9], "parallel hold");
        apb(`PSC_ADDR_STATUS, 1'b0, 32'h0, {15'h0, 5'h0, ~rnd[10:0]}, 32'h107ff, 1'b0);
        $display("test parallel done");
        for (int i = 0; i < 4; i++) begin
            host_u.par_set(9'h0ff, i[1:0]);
            host_u.par_strobe(1'b0);
            host_u.par_strobe(1'b1);
            wait_n(20);
            r0 = rises;
            wait_n(256);
            d = (i == 3) ? 1 : 2 << i;
            check({31'h0, rises - r0 >= 64 / d - 1 && rises - r0 <= 64 / d + 1}, 32'h1, "divide ratio");
        end
        output_gate <= 1'b0;
        wait_n(20);
        r0 = rises;
        wait_n(64);
        check(rises, r0, "gated output");
        host_u.par_set(9'h0ff, 2'h2);
        host_u.par_strobe(1'b0);
        host_u.par_strobe(1'b1);
        min_hi = 1000;
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            output_gate <= rnd[0];
            wait_n(3 + rnd[5:1]);
        end
        output_gate <= 1'b1;
        wait_n(80);
        check({31'h0, min_hi >= 15 && min_hi <= 17}, 32'h1, "full high pulses");
        $display("test divider done");
        for (int i = 0; i < 8; i++) begin
            d = i ^ rnd[2:0];
            {reference_source_select, external_reference_in, xtal_clk_in} <= d[2:0];
            wait_n(10);
            check({31'h0, pll_ref_clk}, {31'h0, d[2] ? d[0] : d[1]}, "reference pick");
        end
        // Floated pins read their default levels; then the bad accesses.
        {output_gate, reference_source_select, external_reference_in, xtal_clk_in} <= 4'h1;
        apb(`PSC_ADDR_PIN_FLOAT, 1'b1, 32'h1ff, 32'h0, 32'h0, 1'b0);
        wait_n(10);
        check({31'h0, pll_ref_clk}, 32'h1, "floating select");
        apb(`PSC_ADDR_STATUS, 1'b0, 32'h0, 32'hc000, 32'hc000, 1'b0);
        apb(`PSC_ADDR_PIN_FLOAT, 1'b0, 32'h0, 32'h1ff, 32'h1ff, 1'b0);
        apb(`PSC_ADDR_PIN_FLOAT, 1'b1, 32'h0, 32'h0, 32'h0, 1'b0);
        wait_n(10);
        apb(`PSC_ADDR_STATUS, 1'b0, 32'h0, 32'h0, 32'hc000, 1'b0);
        apb(12'h00c, 1'b0, 32'h0, 32'h0, 32'hffffffff, 1'b1);
        apb(`PSC_ADDR_STATUS, 1'b1, 32'h5, 32'h0, 32'h0, 1'b1);
        $display("test pins and bus done");
        stop_test();
    end
endmodule : pll_synth_config_logic_test
